/* File: hdl/ccm_clock_control.sv */
// Clock source, oscillator and operating mode control with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "ccm_regs.svh"
`default_nettype none
module ccm_clock_control #(
  parameter int STARTUP_RC_CYCLES = `CCM_STARTUP_RC_CYCLES,
  parameter int STARTUP_XTAL_CYCLES = `CCM_STARTUP_XTAL_CYCLES,
  parameter int LOW_RC_CYCLES = `CCM_LOW_RC_CYCLES,
  parameter int RTC_TICKS = `CCM_RTC_TICKS
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // AXI4-Lite write address, data and response
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Static configuration
  input wire logic [2:0] high_clock_option,
  input wire logic [2:0] fcpu_divide_select,
  input wire logic low_frequency_resonator_config,
  input wire logic watchdog_enable,
  // Wake sources and crystal ticks
  input wire logic port_wake,
  input wire logic timer_wake,
  input wire logic rtc_crystal_tick,
  // Oscillator enables and pin use
  output logic internal_high_rc_oscillator_enable,
  output logic external_high_oscillator_enable,
  output logic rtc_crystal_enable,
  output logic internal_low_rc_oscillator_enable,
  output logic osc_input_pin_gpio,
  output logic osc_output_pin_gpio,
  // Clocks, clock select and start-up reset extension to the core
  output logic system_clock_low_select,
  output logic fcpu_enable,
  output logic watchdog_tick,
  output logic rtc_tick,
  output logic reset_extend
);
  ccm_pkg::ccm_high_option_type high_option;
  ccm_pkg::ccm_power_state_type state;
  ccm_pkg::ccm_power_state_type next_state;
  logic [7:0] osc_ctrl;
  logic [7:0] next_osc_ctrl;
  logic [17:0] startup_count;
  logic [17:0] next_startup_count;
  logic [2:0] fcpu_count;
  logic [2:0] next_fcpu_count;
  logic next_fcpu_enable;
  logic bvalid_q;
  logic next_bvalid;
  logic [1:0] bresp_q;
  logic [1:0] next_bresp;
  logic rvalid_q;
  logic next_rvalid;
  logic [31:0] rdata_q;
  logic [31:0] next_rdata;
  logic [1:0] rresp_q;
  logic [1:0] next_rresp;
  logic write_take;
  logic read_take;
  logic high_stop;
  logic slow_select;
  logic sleep_req;
  logic green_req;
  logic low_run;
  logic high_run;
  logic rtc_run;
  logic low_tick;
  logic slow_fcpu_tick;
  logic rtc_option;

  function automatic logic is_crystal(input ccm_pkg::ccm_high_option_type opt);
    is_crystal = (opt == ccm_pkg::opt_crystal_32k) || (opt == ccm_pkg::opt_crystal_8m) ||
                 (opt == ccm_pkg::opt_crystal_4m) || (opt == ccm_pkg::opt_internal_rc_with_rtc);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      high_option <= ccm_pkg::ccm_high_option_type'(high_clock_option);
    end
  end

  assign high_stop = osc_ctrl[`CCM_HIGH_OSC_STOP_POS];
  assign slow_select = osc_ctrl[`CCM_SLOW_CLOCK_SELECT_POS];
  assign sleep_req = osc_ctrl[`CCM_SLEEP_REQUEST_POS];
  assign green_req = osc_ctrl[`CCM_GREEN_REQUEST_POS];
  assign rtc_option = (high_option == ccm_pkg::opt_internal_rc_with_rtc);

  // low RC off only in sleep or special green
  assign low_run = (state != ccm_pkg::st_sleep) &&
    !((state == ccm_pkg::st_green) && low_frequency_resonator_config && !watchdog_enable);
  assign high_run = !high_stop && (state != ccm_pkg::st_sleep) &&
    !((state == ccm_pkg::st_green) && rtc_option);
  // high stop also stops the crystal
  assign rtc_run = rtc_option && !high_stop && (state != ccm_pkg::st_sleep);

  // internal RC serves both internal options
  assign internal_high_rc_oscillator_enable = high_run &&
    ((high_option == ccm_pkg::opt_internal_rc_only) || rtc_option);
  assign external_high_oscillator_enable = high_run &&
    (high_option != ccm_pkg::opt_internal_rc_only) && !rtc_option;
  assign rtc_crystal_enable = rtc_run;
  assign internal_low_rc_oscillator_enable = low_run;
  // both pins are GPIO for internal RC only; only the output pin is GPIO for external RC
  assign osc_input_pin_gpio = (high_option == ccm_pkg::opt_internal_rc_only);
  assign osc_output_pin_gpio = (high_option == ccm_pkg::opt_internal_rc_only) ||
    (high_option == ccm_pkg::opt_external_rc);
  assign system_clock_low_select = slow_select;
  assign reset_extend = (state == ccm_pkg::st_startup);

  // low RC ticks reach the watchdog
  ccm_tick_div #(
    .WIDTH(16),
    .COUNT(16'(LOW_RC_CYCLES))
  ) u_low_rc (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(low_run),
    .tick_in(1'b1),
    .tick_out(low_tick)
  );
  assign watchdog_tick = low_tick;

  // slow instruction rate is low RC over four
  ccm_tick_div #(
    .WIDTH(3),
    .COUNT(3'(`CCM_SLOW_FCPU_DIV))
  ) u_slow_fcpu (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(low_run),
    .tick_in(low_tick),
    .tick_out(slow_fcpu_tick)
  );

  // timer zero counts half a second of crystal
  ccm_tick_div #(
    .WIDTH(15),
    .COUNT(15'(RTC_TICKS))
  ) u_timer_zero (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(rtc_run),
    .tick_in(rtc_crystal_tick),
    .tick_out(rtc_tick)
  );

  // Bus slave: address and data taken together, one of each at a time
  assign write_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign read_take = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = write_take;
  assign s_axi_wready = write_take;
  assign s_axi_arready = read_take;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    next_state = state;
    next_osc_ctrl = osc_ctrl;
    next_startup_count = startup_count;
    next_fcpu_count = fcpu_count;
    next_fcpu_enable = 1'b0;
    next_bvalid = bvalid_q && !s_axi_bready;
    next_bresp = bresp_q;
    next_rvalid = rvalid_q && !s_axi_rready;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    if (write_take) begin
      next_bvalid = 1'b1;
      next_bresp = `CCM_RESP_OKAY;
      if (s_axi_awaddr[11:2] == `CCM_OSC_CTRL_INDEX) begin
        if (s_axi_wstrb[0]) begin
          next_osc_ctrl = s_axi_wdata[7:0] & `CCM_OSC_CTRL_MASK;
        end
      end else if (s_axi_awaddr[11:2] != `CCM_STATUS_INDEX) begin
        next_bresp = `CCM_RESP_SLVERR;
      end
    end
    if (read_take) begin
      next_rvalid = 1'b1;
      next_rresp = `CCM_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr[11:2] == `CCM_OSC_CTRL_INDEX) begin
        next_rdata[7:0] = osc_ctrl;
      end else if (s_axi_araddr[11:2] == `CCM_STATUS_INDEX) begin
        next_rdata[`CCM_STAT_OPTION_LSB +: 3] = high_option;
        next_rdata[`CCM_STAT_STARTUP_DONE_POS] = (state != ccm_pkg::st_startup);
        next_rdata[`CCM_STAT_HIGH_RUN_POS] = high_run;
        next_rdata[`CCM_STAT_LOW_RUN_POS] = low_run;
        next_rdata[`CCM_STAT_RTC_RUN_POS] = rtc_run;
        next_rdata[`CCM_STAT_LOW_SELECTED_POS] = slow_select;
      end else begin
        next_rresp = `CCM_RESP_SLVERR;
      end
    end
    case (state)
      ccm_pkg::st_startup: begin
        // crystals wait longer than RC sources
        if (startup_count == 18'h0_0000) begin
          next_state = ccm_pkg::st_run;
        end else begin
          next_startup_count = startup_count - 18'h0_0001;
        end
      end
      ccm_pkg::st_run: begin
        // mode field decode, 11 stays running
        if (next_osc_ctrl[`CCM_SLEEP_REQUEST_POS] && !next_osc_ctrl[`CCM_GREEN_REQUEST_POS]) begin
          next_state = ccm_pkg::st_sleep;
        end else if (!next_osc_ctrl[`CCM_SLEEP_REQUEST_POS] &&
                     next_osc_ctrl[`CCM_GREEN_REQUEST_POS]) begin
          next_state = ccm_pkg::st_green;
        end
        if (slow_select) begin
          next_fcpu_enable = slow_fcpu_tick;
        end else if (high_run) begin
          if (fcpu_count >= fcpu_divide_select) begin
            next_fcpu_count = 3'h0;
            next_fcpu_enable = 1'b1;
          end else begin
            next_fcpu_count = fcpu_count + 3'h1;
          end
        end
      end
      ccm_pkg::st_green: begin
        // Green returns to the clock it left from
        if (port_wake || timer_wake) begin
          next_osc_ctrl[`CCM_GREEN_REQUEST_POS] = 1'b0;
          next_state = ccm_pkg::st_run;
        end
      end
      ccm_pkg::st_sleep: begin
        // port wake clears sleep bit, back to normal
        if (port_wake) begin
          next_osc_ctrl[`CCM_SLEEP_REQUEST_POS] = 1'b0;
          next_osc_ctrl[`CCM_SLOW_CLOCK_SELECT_POS] = 1'b0;
          next_osc_ctrl[`CCM_HIGH_OSC_STOP_POS] = 1'b0;
          next_startup_count = is_crystal(high_option) ? 18'(STARTUP_XTAL_CYCLES) :
            18'(STARTUP_RC_CYCLES);
          next_state = ccm_pkg::st_startup;
        end
      end
      default: begin
        next_state = ccm_pkg::st_startup;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ccm_pkg::st_startup;
      osc_ctrl <= `CCM_OSC_CTRL_RESET;
      // start-up length follows the option strap
      startup_count <= is_crystal(ccm_pkg::ccm_high_option_type'(high_clock_option)) ?
        18'(STARTUP_XTAL_CYCLES) : 18'(STARTUP_RC_CYCLES);
      fcpu_count <= 3'h0;
      fcpu_enable <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else begin
      state <= next_state;
      osc_ctrl <= next_osc_ctrl;
      startup_count <= next_startup_count;
      fcpu_count <= next_fcpu_count;
      fcpu_enable <= next_fcpu_enable;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
    end
  end
endmodule // ccm_clock_control
`default_nettype wire

/* File: hdl/ccm_regs.svh */
// Register map, field positions, reset values and timing figures of the clock control block
`ifndef CCM_REGS_SVH
`define CCM_REGS_SVH

// Register indices; byte address is four times the index
`define CCM_OSC_CTRL_INDEX 10'h0ca
`define CCM_STATUS_INDEX 10'h0cb
`define CCM_OSC_CTRL_ADDR {`CCM_OSC_CTRL_INDEX, 2'b00}
`define CCM_STATUS_ADDR {`CCM_STATUS_INDEX, 2'b00}

// Oscillator control fields
`define CCM_HIGH_OSC_STOP_POS 1
`define CCM_SLOW_CLOCK_SELECT_POS 2
`define CCM_SLEEP_REQUEST_POS 3
`define CCM_GREEN_REQUEST_POS 4
`define CCM_OSC_CTRL_RESET 8'h00
`define CCM_OSC_CTRL_MASK 8'h1e

// Status fields
`define CCM_STAT_OPTION_LSB 0
`define CCM_STAT_STARTUP_DONE_POS 4
`define CCM_STAT_HIGH_RUN_POS 5
`define CCM_STAT_LOW_RUN_POS 6
`define CCM_STAT_RTC_RUN_POS 7
`define CCM_STAT_LOW_SELECTED_POS 8

// Timing figures
`define CCM_CLK_HZ 20000000
`define CCM_LOW_RC_HZ 10000
`define CCM_LOW_RC_CYCLES (`CCM_CLK_HZ / `CCM_LOW_RC_HZ)
`define CCM_SLOW_FCPU_DIV 4
`define CCM_RTC_XTAL_HZ 32768
`define CCM_RTC_PERIOD_MS 500
`define CCM_RTC_TICKS (`CCM_RTC_XTAL_HZ * `CCM_RTC_PERIOD_MS / 1000)
`define CCM_STARTUP_RC_US 50
`define CCM_STARTUP_XTAL_US 8000
`define CCM_STARTUP_RC_CYCLES ((`CCM_STARTUP_RC_US * (`CCM_CLK_HZ / 1000000)))
`define CCM_STARTUP_XTAL_CYCLES ((`CCM_STARTUP_XTAL_US * (`CCM_CLK_HZ / 1000000)))

// Bus responses
`define CCM_RESP_OKAY 2'b00
`define CCM_RESP_SLVERR 2'b10

`endif

/* File: hdl/ccm_pkg.sv */
// Types shared by the clock control block
package ccm_pkg;

  // High clock source option, fixed at reset
  typedef enum logic [2:0] {
    opt_internal_rc_only = 3'h0,
    opt_internal_rc_with_rtc = 3'h1,
    opt_external_rc = 3'h2,
    opt_crystal_32k = 3'h3,
    opt_crystal_8m = 3'h4,
    opt_crystal_4m = 3'h5
  } ccm_high_option_type;

  typedef enum {
    st_startup,
    st_run,
    st_green,
    st_sleep
  } ccm_power_state_type;

endpackage

/* File: hdl/ccm_tick_div.sv */
// Enable-pulse divider: counts input ticks and emits one pulse every COUNT ticks
`timescale 1ns/1ps
`default_nettype none
module ccm_tick_div #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] COUNT = 16'h0004
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Tick stream
  input wire logic run,
  input wire logic tick_in,
  output logic tick_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_tick_out;

  always_comb begin
    next_count = count;
    next_tick_out = 1'b0;
    // Stopped source restarts a full period, no stale partial count
    if (!run) begin
      next_count = '0;
    end else if (tick_in) begin
      if (count == COUNT - 1'b1) begin
        next_count = '0;
        next_tick_out = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count <= '0;
      tick_out <= 1'b0;
    end else begin
      count <= next_count;
      tick_out <= next_tick_out;
    end
  end
endmodule // ccm_tick_div
`default_nettype wire

/* File: sim/ccm_clock_control_checker.sv */
// Port-level assertions for the clock control block
`timescale 1ns/1ps
`default_nettype none
module ccm_clock_control_checker #(
  parameter int LOW_RC_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Bus write handshake
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  // Configuration
  input wire logic [2:0] high_clock_option,
  input wire logic [2:0] fcpu_divide_select,
  input wire logic low_frequency_resonator_config,
  input wire logic watchdog_enable,
  // Oscillators, pins and clocks
  input wire logic internal_high_rc_oscillator_enable,
  input wire logic external_high_oscillator_enable,
  input wire logic rtc_crystal_enable,
  input wire logic internal_low_rc_oscillator_enable,
  input wire logic osc_input_pin_gpio,
  input wire logic osc_output_pin_gpio,
  input wire logic system_clock_low_select,
  input wire logic fcpu_enable,
  input wire logic watchdog_tick,
  input wire logic reset_extend
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [2:0] opt_q;
  int wd_cnt;
  logic wd_vld;
  int fc_cnt;
  logic fc_vld;
  int fc_lim;
  assign fc_lim = system_clock_low_select ? 4 * LOW_RC_CYCLES - 1 : int'(fcpu_divide_select);
  // Period checks restart whenever the rate may legally change
  always_ff @(posedge clk_sys) begin
    opt_q <= reset ? high_clock_option : opt_q;
    wd_cnt <= watchdog_tick ? 0 : wd_cnt + 1;
    wd_vld <= !reset && internal_low_rc_oscillator_enable && (watchdog_tick || wd_vld);
    fc_cnt <= fcpu_enable ? 0 : fc_cnt + 1;
    fc_vld <= !reset && $stable(system_clock_low_select) && $stable(fcpu_divide_select)
      && (fcpu_enable || (fc_vld && fc_cnt < fc_lim));
  end
  sequence startup_hold;
    reset_extend [*3];
  endsequence
  AST_STARTUP_HOLD: assert property ($fell(reset) |-> startup_hold)
    else $error("start-up hold too short");
  AST_PINS_RC_ONLY: assert property (opt_q == 3'h0 |->
    osc_input_pin_gpio && osc_output_pin_gpio)
    else $error("pins not GPIO");
  AST_PINS_RTC: assert property (opt_q == 3'h1 |->
    !osc_input_pin_gpio && !osc_output_pin_gpio)
    else $error("crystal pins used as GPIO");
  AST_PINS_EXT: assert property (opt_q == 3'h2 |->
    !osc_input_pin_gpio && osc_output_pin_gpio)
    else $error("external source pin use wrong");
  AST_CRYSTAL_OPT: assert property (rtc_crystal_enable |-> opt_q == 3'h1)
    else $error("crystal runs under wrong option");
  AST_LOW_STOP: assert property (!internal_low_rc_oscillator_enable |->
    (!internal_high_rc_oscillator_enable && !external_high_oscillator_enable)
    || (low_frequency_resonator_config && !watchdog_enable))
    else $error("low oscillator stopped outside allowed modes");
  AST_WDT_PERIOD: assert property (watchdog_tick && wd_vld |-> wd_cnt == LOW_RC_CYCLES - 1)
    else $error("watchdog tick period wrong");
  AST_FCPU_RATE: assert property (fcpu_enable && fc_vld
    && $stable(system_clock_low_select) && $stable(fcpu_divide_select) |-> fc_cnt == fc_lim)
    else $error("instruction cycle period wrong");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
endmodule // ccm_clock_control_checker

bind ccm_clock_control ccm_clock_control_checker #(.LOW_RC_CYCLES(LOW_RC_CYCLES))
  i_ccm_clock_control_checker (.clk_sys, .reset, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bvalid, .high_clock_option, .fcpu_divide_select, .low_frequency_resonator_config,
  .watchdog_enable, .internal_high_rc_oscillator_enable, .external_high_oscillator_enable,
  .rtc_crystal_enable, .internal_low_rc_oscillator_enable, .osc_input_pin_gpio,
  .osc_output_pin_gpio, .system_clock_low_select, .fcpu_enable, .watchdog_tick, .reset_extend);
`default_nettype wire

/* File: sim/ccm_xtal_model.sv */
// Behavioural 32768 Hz crystal: one pulse every third system cycle while driven
`timescale 1ns/1ps
`default_nettype none
module ccm_xtal_model (
  // Clock and drive from the block
  input wire logic clk_sys,
  input wire logic enable,
  // Crystal cycle pulses
  output logic tick
);
  logic [1:0] phase = 2'h0;
  initial tick = 1'b0;
  always @(posedge clk_sys) begin
    phase <= (!enable || phase == 2'h2) ? 2'h0 : phase + 2'h1;
    tick <= enable && phase == 2'h2;
  end
endmodule // ccm_xtal_model
`default_nettype wire

/* File: sim/ccm_clock_control_bench.sv */
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`include "ccm_regs.svh"
`default_nettype none
module ccm_clock_control_bench;
  localparam int RC = 4;
  localparam int XT = 20;
  localparam int LR = 8;
  localparam int RT = 4;
  localparam logic [11:0] CT = `CCM_OSC_CTRL_ADDR;
  localparam logic [11:0] ST = `CCM_STATUS_ADDR;
  localparam logic [1:0] OK = `CCM_RESP_OKAY;
  localparam logic [1:0] ER = `CCM_RESP_SLVERR;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0] high_clock_option = 3'h0, fcpu_divide_select = 3'h2;
  logic low_frequency_resonator_config = 1'b0, watchdog_enable = 1'b1;
  logic port_wake = 1'b0, timer_wake = 1'b0;
  logic rtc_crystal_tick, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, internal_high_rc_oscillator_enable, external_high_oscillator_enable;
  logic rtc_crystal_enable, internal_low_rc_oscillator_enable, osc_input_pin_gpio;
  logic osc_output_pin_gpio, system_clock_low_select, fcpu_enable, watchdog_tick;
  logic rtc_tick, reset_extend;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int error_cnt = 0;
  int num_checks = 0;
  int g;
  always #25 clk_sys = ~clk_sys;
  ccm_clock_control #(.STARTUP_RC_CYCLES(RC), .STARTUP_XTAL_CYCLES(XT),
    .LOW_RC_CYCLES(LR), .RTC_TICKS(RT)) i_ccm_clock_control (.clk_sys, .reset,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .high_clock_option,
    .fcpu_divide_select, .low_frequency_resonator_config, .watchdog_enable, .port_wake,
    .timer_wake, .rtc_crystal_tick, .internal_high_rc_oscillator_enable,
    .external_high_oscillator_enable, .rtc_crystal_enable,
    .internal_low_rc_oscillator_enable, .osc_input_pin_gpio, .osc_output_pin_gpio,
    .system_clock_low_select, .fcpu_enable, .watchdog_tick, .rtc_tick, .reset_extend);
  ccm_xtal_model i_ccm_xtal_model (.clk_sys, .enable(rtc_crystal_enable),
    .tick(rtc_crystal_tick));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(posedge clk_sys); n++; end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task do_reset(input logic [2:0] opt, input int p);
    int n;
    n = 0;
    @(posedge clk_sys);
    reset <= 1'b1;
    high_clock_option <= opt;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    do begin @(posedge clk_sys); n++; end while (reset_extend === 1'b1 && n < 1000);
    chk(32'(n >= p && n <= p + 3), 32'h1);
  endtask
  function automatic logic pls(input int w);
    case (w)
      0: return fcpu_enable;
      1: return watchdog_tick;
      default: return rtc_tick;
    endcase
  endfunction
  // Cycles between pulses; for the crystal, crystal ticks instead of cycles
  task gap(input int w, output int c);
    int n;
    n = 0;
    c = 0;
    do begin @(posedge clk_sys); n++; end while (pls(w) !== 1'b1 && n < 2000);
    do begin
      @(posedge clk_sys);
      n++;
      c += (w == 2) ? int'(rtc_crystal_tick) : 1;
    end while (pls(w) !== 1'b1 && n < 2000);
  endtask
  task wake(input logic by_timer);
    int n;
    n = 0;
    @(posedge clk_sys);
    if (by_timer) timer_wake <= 1'b1;
    else port_wake <= 1'b1;
    @(posedge clk_sys);
    timer_wake <= 1'b0;
    port_wake <= 1'b0;
    do begin @(posedge clk_sys); n++; end while ((reset_extend !== 1'b0 || n < 3) && n < 200);
    chk({31'h0, reset_extend}, 32'h0);
  endtask

  task t_rc_only;
    do_reset(3'h0, RC);
    chk({30'h0, osc_input_pin_gpio, osc_output_pin_gpio}, 32'h3);
    rchk(CT, 32'hffff_ffff, 32'h0, OK);
    rchk(ST, 32'h17, 32'h10, OK);
    wchk(CT, 32'hffff_ffe7, OK);
    rchk(CT, 32'hffff_ffff, 32'h6, OK);
    chk({31'h0, system_clock_low_select}, 32'h1);
    wchk(CT, 32'h0, OK);
    wchk(12'h000, 32'h0, ER);
    rchk(12'h004, 32'h0, 32'h0, ER);
    // Strap moves at run time; block must ignore it
    high_clock_option <= 3'h1;
    rchk(ST, 32'h7, 32'h0, OK);
    chk({30'h0, osc_input_pin_gpio, osc_output_pin_gpio}, 32'h3);
    high_clock_option <= 3'h0;
    $display("test rc_only done");
  endtask
  task t_fcpu;
    gap(0, g);
    gap(0, g);
    chk(32'(g), 32'h3);
    wchk(CT, 32'h4, OK);
    gap(1, g);
    chk(32'(g), 32'(LR));
    gap(0, g);
    gap(0, g);
    chk(32'(g), 32'(4 * LR));
    wchk(CT, 32'h0, OK);
    $display("test fcpu done");
  endtask
  task t_modes;
    low_frequency_resonator_config <= 1'b1;
    watchdog_enable <= 1'b0;
    wchk(CT, 32'h10, OK);
    chk({30'h0, internal_low_rc_oscillator_enable, internal_high_rc_oscillator_enable},
      32'h1);
    wake(1'b1);
    rchk(CT, 32'h1e, 32'h0, OK);
    watchdog_enable <= 1'b1;
    wchk(CT, 32'h10, OK);
    chk({31'h0, internal_low_rc_oscillator_enable}, 32'h1);
    wake(1'b0);
    wchk(CT, 32'h18, OK);
    gap(0, g);
    chk(32'(g), 32'h3);
    wchk(CT, 32'h0c, OK);
    chk({30'h0, internal_low_rc_oscillator_enable, internal_high_rc_oscillator_enable},
      32'h0);
    wake(1'b0);
    rchk(CT, 32'h1e, 32'h0, OK);
    $display("test modes done");
  endtask
  task t_rtc;
    do_reset(3'h1, XT);
    chk({29'h0, osc_input_pin_gpio, osc_output_pin_gpio, rtc_crystal_enable}, 32'h1);
    gap(2, g);
    gap(2, g);
    chk(32'(g), 32'(RT));
    wchk(CT, 32'h2, OK);
    chk({30'h0, internal_high_rc_oscillator_enable, rtc_crystal_enable}, 32'h0);
    wchk(CT, 32'h0, OK);
    do_reset(3'h2, RC);
    chk({29'h0, osc_input_pin_gpio, osc_output_pin_gpio, external_high_oscillator_enable},
      32'h3);
    $display("test sources done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    t_rc_only;
    t_fcpu;
    t_modes;
    t_rtc;
    final_report;
  end
  // Whole run needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    final_report;
  end
endmodule // ccm_clock_control_bench
`default_nettype wire
